/* File: rtl/ocfm_pkg.sv */
// Package: command codes, field layout, reset values and timing of the overcurrent manager
package ocfm_pkg;
   // -----------------------------------------------------------------
   // Command codes and phase selector
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_FLT_LIM = 8'h46;
   localparam logic [7:0] CMD_FLT_ACT = 8'h47;
   localparam logic [7:0] CMD_WRN_LIM = 8'h4A;
   localparam logic [7:0] PHASE_ALL = 8'hFF;
   // -----------------------------------------------------------------
   // Field positions and reset values
   // -----------------------------------------------------------------
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int MAN_MSB = 10;
   localparam int RESP_MSB = 7;
   localparam int RESP_LSB = 6;
   localparam int RETRY_MSB = 5;
   localparam int RETRY_LSB = 3;
   localparam int DLY_MSB = 2;
   localparam logic [4:0] EXP_RST = 5'h1E;
   localparam logic [15:0] FLT_LIM_RST = 16'hF0F8;
   localparam logic [15:0] WRN_LIM_RST = 16'hF0C8;
   localparam logic [7:0] ACT_RST = 8'hBA;
   localparam logic [1:0] RESP_DELAYED = 2'h2;
   localparam logic [1:0] RESP_IMMED = 2'h3;
   localparam logic [2:0] RETRY_LATCH = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // -----------------------------------------------------------------
   // Current scale, held in quarter amperes
   // -----------------------------------------------------------------
   localparam int Q_PER_AMP = 4;
   localparam int MAX_AMP = 62;
   localparam int MIN_AMP = 8;
   localparam int STEP_AMP = 2;
   localparam int Q_MAX = MAX_AMP * Q_PER_AMP;
   localparam int Q_MIN = MIN_AMP * Q_PER_AMP;
   localparam int Q_STEP = STEP_AMP * Q_PER_AMP;
   localparam logic [4:0] STEP_MIN = 5'(MIN_AMP / STEP_AMP);
   localparam logic [4:0] STEP_MAX = 5'(MAX_AMP / STEP_AMP);
   // -----------------------------------------------------------------
   // Timing: shutdown delay in switching clocks, hiccup base in cycles
   // -----------------------------------------------------------------
   localparam logic [2:0] DLY_MID_CODE = 3'h2;
   localparam logic [2:0] DLY_LONG_CODE = 3'h5;
   localparam logic [2:0] DLY_SHORT = 3'h1;
   localparam logic [2:0] DLY_MID = 3'h3;
   localparam logic [2:0] DLY_LONG = 3'h7;
   localparam int CLK_MHZ = 250;
   localparam int TON_RISE_NS = 1000;
   localparam int TON_RISE_CYC = (TON_RISE_NS * CLK_MHZ + 999) / 1000;
   // -----------------------------------------------------------------
   // Status bit positions
   // -----------------------------------------------------------------
   localparam int SB_NOA_BIT = 0;
   localparam int SB_CML_BIT = 1;
   localparam int SB_IOUT_OC_BIT = 4;
   localparam int SW_IOUT_BIT = 14;
   localparam int SI_OCW_BIT = 5;
   localparam int SI_OCF_BIT = 7;
   localparam int SC_DATA_BIT = 6;
   localparam int SC_CMD_BIT = 7;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_START = 3'b001,
      ST_RUN = 3'b010,
      ST_HICCUP = 3'b011,
      ST_LATCHED = 3'b100
   } ocfm_state_e;
endpackage : ocfm_pkg

/* File: rtl/ocfm_pwm_if.sv */
// Interface between the control domain and the switching-clock delay logic
`timescale 1ns/100ps
interface ocfm_pwm_if;
   logic [2:0] dly_sel;
   logic detect_tgl;
   logic shutdown_tgl;
   modport ctl (output dly_sel, input detect_tgl, input shutdown_tgl);
   modport pwm (input dly_sel, output detect_tgl, output shutdown_tgl);
endinterface : ocfm_pwm_if

/* File: rtl/ocfm_pwm_delay.sv */
// Switching-clock domain: comparator sync and shutdown delay count
`timescale 1ns/100ps
module ocfm_pwm_delay #(
   parameter int NPH = 2
) (
   input wire logic pwm_clk_in,
   input wire logic reset_in,
   input wire logic [NPH-1:0] fault_trip_in,
   ocfm_pwm_if.pwm link
);
   typedef struct packed {
      logic [NPH-1:0] trip_s1;
      logic [NPH-1:0] trip_s2;
      logic trip_d;
      logic [2:0] dsel_s1;
      logic [2:0] dsel_s2;
      logic [2:0] cnt;
      logic armed;
      logic det_t;
      logic sd_t;
   } ocfm_dly_s;

   ocfm_dly_s s_q;
   ocfm_dly_s s_d;
   logic [2:0] dly_cyc;
   logic trip_any;

   // Each pin is synchronised alone; merging raw pins first would pass glitches on
   assign trip_any = |s_q.trip_s2; // [R2]

   // Delay field only changes by host write; it is held long before a fault uses it
   assign dly_cyc = (s_q.dsel_s2 < ocfm_pkg::DLY_MID_CODE) ? ocfm_pkg::DLY_SHORT :
                    (s_q.dsel_s2 < ocfm_pkg::DLY_LONG_CODE) ? ocfm_pkg::DLY_MID :
                    ocfm_pkg::DLY_LONG;

   always_comb
   begin
      s_d = s_q;
      s_d.trip_s1 = fault_trip_in;
      s_d.trip_s2 = s_q.trip_s1;
      s_d.trip_d = trip_any;
      s_d.dsel_s1 = link.dly_sel;
      s_d.dsel_s2 = s_q.dsel_s1;
      if (trip_any && !s_q.trip_d)
      begin
         s_d.det_t = ~s_q.det_t;
         s_d.cnt = dly_cyc - 3'h1; // [R13]
         s_d.armed = 1'b1;
      end
      else if (s_q.armed)
      begin
         if (!trip_any)
            s_d.armed = 1'b0;
         else if (s_q.cnt == 3'h0)
         begin
            s_d.sd_t = ~s_q.sd_t;
            s_d.armed = 1'b0;
         end
         else
            s_d.cnt = s_q.cnt - 3'h1;
      end
   end

   always_ff @(posedge pwm_clk_in or posedge reset_in)
   begin
      if (reset_in)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign link.detect_tgl = s_q.det_t;
   assign link.shutdown_tgl = s_q.sd_t;

   default clocking cb @(posedge pwm_clk_in); endclocking
   default disable iff (reset_in);

   det_toggle_a: assert property ($rose(trip_any) |=> $changed(s_q.det_t)) // [R10]
      else $error("fault detect not passed on");
   mid_delay_a: assert property ($rose(trip_any) && dly_cyc == 3'h3 ##1 trip_any[*3] // [R13]
      |=> $changed(s_q.sd_t))
      else $error("three-clock shutdown delay wrong");
endmodule : ocfm_pwm_delay

/* File: rtl/ocfm_top.sv */
// Overcurrent limit commands, status, and shutdown/hiccup policy for one output
// Behaviour
// [R1] Limit words are linear: signed exponent 15:11, signed mantissa 10:0, exponent resets -2.
// [R2] Each phase has its own comparator; any phase tripping faults the stack.
// [R3] Comparators realise 8 A to 62 A in 2 A steps, rounding up.
// [R4] Values below 8 A are stored as written but the comparator uses 8 A.
// [R5] A store or restore rounds each stored limit to the nearest quarter ampere.
// [R6] Fault limit accepts 62 A per phase, or 62 A times phases for all.
// [R7] Writing with all phases selected loads each phase with value divided by phases.
// [R8] Reading with all phases selected returns phase zero times phase count.
// [R9] With one phase selected, writes and reads touch only that phase.
// [R10] A fault sets fault bits in status byte, word and current status, then alerts.
// [R11] Action 00/01 continue, 10 shuts down after delay, 11 shuts down at once.
// [R12] Retry 0 latches off, 1-6 restarts that many times, 7 retries forever.
// [R13] Delay code sets 1, 3 or 7 switching clocks and hiccup multiple of rise time.
// [R14] Out-of-range writes are refused, flagged as invalid data, and alert the host.
// [R15] Warnings are detected and flagged for each phase independently.
// [R16] A warning sets none-of-above, current summary and warning bits, then alerts.
// [R17] Warning limit accepts up to 62 A times the phase count.
// [R18] Limits are word commands, action a byte command; changes act while running.
// [R19] Retry count clears on a successful start or when output is commanded off.
`timescale 1ns/100ps
module ocfm_top #(
   parameter int NPH = 2,
   parameter int HICCUP_BASE_CYC = ocfm_pkg::TON_RISE_CYC
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic pwm_clk_in,
   input wire logic cmd_valid_in,
   input wire logic cmd_write_in,
   input wire logic cmd_word_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic [15:0] cmd_wdata_in,
   input wire logic [7:0] phase_sel_in,
   input wire logic nvm_reload_in,
   input wire logic clear_faults_in,
   input wire logic enable_in,
   input wire logic startup_ok_in,
   input wire logic [NPH-1:0] fault_trip_in,
   input wire logic [NPH-1:0] warn_trip_in,
   output logic rsp_valid_out,
   output logic rsp_error_out,
   output logic [15:0] rsp_data_out,
   output logic [NPH*5-1:0] fault_step_out,
   output logic [NPH*5-1:0] warn_step_out,
   output logic [NPH-1:0] warn_phase_out,
   output logic [7:0] status_byte_out,
   output logic [15:0] status_word_out,
   output logic [7:0] status_iout_out,
   output logic [7:0] status_cml_out,
   output logic alert_n_out,
   output logic power_en_out
);
   localparam int IW = (NPH > 1) ? $clog2(NPH) : 1;
   localparam logic [7:0] NPH8 = 8'(NPH);

   typedef struct packed {
      logic [NPH-1:0][15:0] flt;
      logic [NPH-1:0][15:0] wrn;
      logic [7:0] act;
      logic [NPH-1:0][4:0] fstep;
      logic [NPH-1:0][4:0] wstep;
      logic [NPH-1:0] wsync1;
      logic [NPH-1:0] wsync2;
      logic [NPH-1:0] wprev;
      logic [NPH-1:0] wflag;
      logic [2:0] det_s;
      logic [2:0] sd_s;
      logic ocf;
      logic ocw;
      logic cml_data;
      logic cml_cmd;
      logic rsp_valid;
      logic rsp_err;
      logic [15:0] rsp_data;
      logic alert_n;
      logic pwr;
      ocfm_pkg::ocfm_state_e st;
      logic [2:0] tries;
      logic [31:0] hic;
   } ocfm_core_s;

   localparam ocfm_core_s CORE_RST = '{
      flt: {NPH{ocfm_pkg::FLT_LIM_RST}},
      wrn: {NPH{ocfm_pkg::WRN_LIM_RST}},
      act: ocfm_pkg::ACT_RST,
      fstep: {NPH{ocfm_pkg::STEP_MAX}},
      wstep: {NPH{ocfm_pkg::STEP_MAX}},
      alert_n: 1'b1,
      st: ocfm_pkg::ST_OFF,
      default: '0
   };

   ocfm_core_s s_q;
   ocfm_core_s s_d;
   ocfm_pwm_if link ();

   // -----------------------------------------------------------------
   // Linear decode, in quarter amperes
   // -----------------------------------------------------------------
   function automatic logic [31:0] lin_q(input logic [15:0] w, input logic up);
      logic signed [5:0] sh;
      logic [31:0] m;
      logic [4:0] n;
      logic [31:0] r;
      sh = 6'(signed'(w[ocfm_pkg::EXP_MSB:ocfm_pkg::EXP_LSB])) + 6'sh2; // [R1]
      m = {21'h0, w[ocfm_pkg::MAN_MSB:0]};
      n = 5'(-sh);
      if (!sh[5])
         r = m << sh[4:0];
      else if (up)
         r = (m + ((32'h1 << n) - 32'h1)) >> n;
      else
         r = (m + ((32'h1 << n) >> 1)) >> n;
      return r;
   endfunction : lin_q

   function automatic logic [15:0] q_word(input logic [31:0] q);
      return {ocfm_pkg::EXP_RST, 11'(q)};
   endfunction : q_word

   // Negative mantissas never get stored, but the step decode still guards them
   function automatic logic [4:0] hw_step(input logic [15:0] w);
      logic [31:0] q;
      q = lin_q(w, 1'b1);
      if (w[ocfm_pkg::MAN_MSB] || q < 32'(ocfm_pkg::Q_MIN))
         return ocfm_pkg::STEP_MIN; // [R4]
      else if (q > 32'(ocfm_pkg::Q_MAX))
         return ocfm_pkg::STEP_MAX;
      else
         return 5'((q + 32'(ocfm_pkg::Q_STEP - 1)) / 32'(ocfm_pkg::Q_STEP)); // [R3]
   endfunction : hw_step

   // -----------------------------------------------------------------
   // Per-phase comparator steps
   // -----------------------------------------------------------------
   logic [NPH-1:0][4:0] fstep_w;
   logic [NPH-1:0][4:0] wstep_w;
   for (genvar p = 0; p < NPH; p++)
   begin : g_ph
      assign fstep_w[p] = hw_step(s_q.flt[p]); // [R3]
      assign wstep_w[p] = hw_step(s_q.wrn[p]); // [R15]
   end

   // -----------------------------------------------------------------
   // Command decode helpers
   // -----------------------------------------------------------------
   logic sel_all;
   logic sel_ok;
   logic [IW-1:0] idx;
   logic [31:0] wq;
   logic [31:0] lim;
   logic w_bad;
   logic is_lim;
   logic is_flt;
   logic det_ev;
   logic sd_ev;
   logic [NPH-1:0] wrise;
   logic shut;
   logic [1:0] resp;
   logic [2:0] retry;
   logic [2:0] mult;
   logic [15:0] rd_lim;

   always_comb
   begin
      sel_all = phase_sel_in == ocfm_pkg::PHASE_ALL;
      sel_ok = sel_all || phase_sel_in < NPH8;
      idx = phase_sel_in[IW-1:0];
      wq = lin_q(cmd_wdata_in, 1'b1);
      lim = sel_all ? 32'(ocfm_pkg::Q_MAX * NPH) : 32'(ocfm_pkg::Q_MAX); // [R6] [R17]
      w_bad = cmd_wdata_in[ocfm_pkg::MAN_MSB] || wq > lim; // [R14]
      is_flt = cmd_code_in == ocfm_pkg::CMD_FLT_LIM;
      is_lim = is_flt || cmd_code_in == ocfm_pkg::CMD_WRN_LIM;
      det_ev = s_q.det_s[1] ^ s_q.det_s[2];
      sd_ev = s_q.sd_s[1] ^ s_q.sd_s[2];
      wrise = s_q.wsync2 & ~s_q.wprev; // [R15]
      resp = s_q.act[ocfm_pkg::RESP_MSB:ocfm_pkg::RESP_LSB];
      retry = s_q.act[ocfm_pkg::RETRY_MSB:ocfm_pkg::RETRY_LSB];
      mult = (s_q.act[ocfm_pkg::DLY_MSB:0] < ocfm_pkg::DLY_MID_CODE) ? 3'h1 :
             s_q.act[ocfm_pkg::DLY_MSB:0]; // [R13]
      shut = (s_q.st == ocfm_pkg::ST_RUN || s_q.st == ocfm_pkg::ST_START) &&
             ((det_ev && resp == ocfm_pkg::RESP_IMMED) ||
              (sd_ev && resp == ocfm_pkg::RESP_DELAYED)); // [R11]
      rd_lim = is_flt ? s_q.flt[0] : s_q.wrn[0];
   end

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.fstep = fstep_w; // [R18]
      s_d.wstep = wstep_w;
      s_d.det_s = {s_q.det_s[1:0], link.detect_tgl};
      s_d.sd_s = {s_q.sd_s[1:0], link.shutdown_tgl};
      s_d.wsync1 = warn_trip_in;
      s_d.wsync2 = s_q.wsync1;
      s_d.wprev = s_q.wsync2;
      s_d.rsp_valid = 1'b0;
      s_d.rsp_err = 1'b0;
      s_d.rsp_data = 16'h0000;

      // Clear first, then sets, so an event in the clear cycle survives
      if (clear_faults_in)
      begin
         s_d.ocf = 1'b0;
         s_d.ocw = 1'b0;
         s_d.cml_data = 1'b0;
         s_d.cml_cmd = 1'b0;
         s_d.wflag = '0;
      end
      s_d.ocf = s_d.ocf | det_ev; // [R10]
      s_d.ocw = s_d.ocw | (|wrise); // [R16]
      s_d.wflag = s_d.wflag | wrise; // [R15]

      if (nvm_reload_in)
      begin
         for (int p = 0; p < NPH; p++)
         begin
            s_d.flt[p] = q_word(lin_q(s_q.flt[p], 1'b0)); // [R5]
            s_d.wrn[p] = q_word(lin_q(s_q.wrn[p], 1'b0));
         end
      end

      if (cmd_valid_in)
      begin
         s_d.rsp_valid = 1'b1;
         if (is_lim)
         begin
            if (!cmd_word_in || !sel_ok)
            begin
               s_d.rsp_err = 1'b1; // [R18]
               s_d.cml_cmd = 1'b1;
            end
            else if (cmd_write_in && w_bad)
            begin
               s_d.rsp_err = 1'b1; // [R14]
               s_d.cml_data = 1'b1;
            end
            else if (cmd_write_in && sel_all)
            begin
               for (int p = 0; p < NPH; p++)
               begin
                  if (is_flt)
                     s_d.flt[p] = q_word(32'(wq / NPH)); // [R7]
                  else
                     s_d.wrn[p] = q_word(32'(wq / NPH));
               end
            end
            else if (cmd_write_in)
            begin
               if (is_flt)
                  s_d.flt[idx] = cmd_wdata_in; // [R9] [R4]
               else
                  s_d.wrn[idx] = cmd_wdata_in;
            end
            else if (sel_all)
               s_d.rsp_data = q_word(32'(lin_q(rd_lim, 1'b0) * NPH)); // [R8]
            else
               s_d.rsp_data = is_flt ? s_q.flt[idx] : s_q.wrn[idx]; // [R9]
         end
         else if (cmd_code_in == ocfm_pkg::CMD_FLT_ACT)
         begin
            if (cmd_word_in)
            begin
               s_d.rsp_err = 1'b1; // [R18]
               s_d.cml_cmd = 1'b1;
            end
            else if (cmd_write_in)
               s_d.act = cmd_wdata_in[7:0];
            else
               s_d.rsp_data = {8'h00, s_q.act};
         end
         else
         begin
            s_d.rsp_err = 1'b1;
            s_d.cml_cmd = 1'b1;
         end
      end
      s_d.alert_n = ~(s_d.ocf | s_d.ocw | s_d.cml_data | s_d.cml_cmd); // [R10] [R14] [R16]

      case (s_q.st)
         ocfm_pkg::ST_OFF:
         begin
            if (enable_in)
            begin
               s_d.st = ocfm_pkg::ST_START;
               s_d.pwr = 1'b1;
            end
         end
         ocfm_pkg::ST_START:
         begin
            if (startup_ok_in)
            begin
               s_d.st = ocfm_pkg::ST_RUN;
               s_d.tries = 3'h0; // [R19]
            end
         end
         ocfm_pkg::ST_RUN:
            s_d.st = ocfm_pkg::ST_RUN;
         ocfm_pkg::ST_HICCUP:
         begin
            if (s_q.hic != 32'h0)
               s_d.hic = s_q.hic - 32'h1;
            else if (retry == ocfm_pkg::RETRY_FOREVER || s_q.tries < retry)
            begin
               if (retry != ocfm_pkg::RETRY_FOREVER)
                  s_d.tries = s_q.tries + 3'h1; // [R12]
               s_d.st = ocfm_pkg::ST_START;
               s_d.pwr = 1'b1;
            end
            else
               s_d.st = ocfm_pkg::ST_LATCHED; // [R12]
         end
         ocfm_pkg::ST_LATCHED:
            s_d.st = ocfm_pkg::ST_LATCHED;
         default:
            s_d.st = ocfm_pkg::ST_OFF;
      endcase

      if (shut)
      begin
         s_d.pwr = 1'b0;
         s_d.hic = 32'(mult) * 32'(HICCUP_BASE_CYC) - 32'h1; // [R13]
         s_d.st = (retry == ocfm_pkg::RETRY_LATCH) ? ocfm_pkg::ST_LATCHED :
                  ocfm_pkg::ST_HICCUP; // [R12]
      end
      if (!enable_in)
      begin
         s_d.st = ocfm_pkg::ST_OFF;
         s_d.pwr = 1'b0;
         s_d.tries = 3'h0; // [R19]
      end
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         s_q <= CORE_RST;
      else
         s_q <= s_d;
   end

   // -----------------------------------------------------------------
   // Switching-clock delay logic and outputs
   // -----------------------------------------------------------------
   assign link.dly_sel = s_q.act[ocfm_pkg::DLY_MSB:0];

   ocfm_pwm_delay #(
      .NPH(NPH)
   ) u_dly (
      .pwm_clk_in(pwm_clk_in),
      .reset_in(reset_in),
      .fault_trip_in(fault_trip_in),
      .link(link.pwm)
   );

   always_comb
   begin
      status_byte_out = 8'h00;
      status_byte_out[ocfm_pkg::SB_NOA_BIT] = s_q.ocw;
      status_byte_out[ocfm_pkg::SB_CML_BIT] = s_q.cml_data | s_q.cml_cmd;
      status_byte_out[ocfm_pkg::SB_IOUT_OC_BIT] = s_q.ocf;
      status_word_out = {8'h00, status_byte_out};
      status_word_out[ocfm_pkg::SW_IOUT_BIT] = s_q.ocf | s_q.ocw;
      status_iout_out = 8'h00;
      status_iout_out[ocfm_pkg::SI_OCF_BIT] = s_q.ocf;
      status_iout_out[ocfm_pkg::SI_OCW_BIT] = s_q.ocw;
      status_cml_out = 8'h00;
      status_cml_out[ocfm_pkg::SC_DATA_BIT] = s_q.cml_data;
      status_cml_out[ocfm_pkg::SC_CMD_BIT] = s_q.cml_cmd;
   end

   assign rsp_valid_out = s_q.rsp_valid;
   assign rsp_error_out = s_q.rsp_err;
   assign rsp_data_out = s_q.rsp_data;
   assign fault_step_out = s_q.fstep;
   assign warn_step_out = s_q.wstep;
   assign warn_phase_out = s_q.wflag;
   assign alert_n_out = s_q.alert_n;
   assign power_en_out = s_q.pwr;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   exp_reset_a: assert property ($fell(reset_in) |-> s_q.flt[0][15:11] == 5'h1E) // [R1]
      else $error("limit exponent not at reset value");
   step_floor_a: assert property (s_q.fstep[0] >= 5'h4 && s_q.wstep[0] >= 5'h4) // [R4]
      else $error("comparator step below floor");
   step_track_a: assert property (cmd_valid_in && cmd_write_in && cmd_word_in && is_flt // [R3]
      && phase_sel_in == 8'h00 && !w_bad && !nvm_reload_in
      ##1 !(cmd_valid_in && cmd_write_in) && !nvm_reload_in
      |=> s_q.fstep[0] == hw_step($past(cmd_wdata_in, 2)))
      else $error("comparator step does not follow limit");
   all_write_a: assert property (cmd_valid_in && cmd_write_in && cmd_word_in && is_flt // [R7]
      && sel_all && !w_bad |=> s_q.flt[0] == q_word(32'($past(wq) / NPH)))
      else $error("all-phase write not divided");
   all_read_a: assert property (cmd_valid_in && !cmd_write_in && cmd_word_in && is_flt // [R8]
      && sel_all |=> rsp_valid_out
      && rsp_data_out == q_word(32'(lin_q($past(s_q.flt[0]), 1'b0) * NPH)))
      else $error("all-phase read not scaled");
   ocf_flag_a: assert property (det_ev |=> s_q.ocf && status_word_out[14] && !alert_n_out) // [R10]
      else $error("fault status or alert missing");
   imm_off_a: assert property (det_ev && resp == 2'h3 && s_q.st == ocfm_pkg::ST_RUN // [R11]
      |=> !power_en_out)
      else $error("immediate shutdown missed");
   keep_on_a: assert property (det_ev && !resp[1] && s_q.st == ocfm_pkg::ST_RUN && enable_in // [R11]
      |=> s_q.st == ocfm_pkg::ST_RUN && power_en_out)
      else $error("ignored fault stopped output");
   latch_a: assert property (shut && retry == 3'h0 && enable_in // [R12]
      |=> s_q.st == ocfm_pkg::ST_LATCHED ##1 !power_en_out)
      else $error("zero retry did not latch off");
   ocw_flag_a: assert property (wrise[0] |=> s_q.ocw && s_q.wflag[0] && status_byte_out[0]) // [R16]
      else $error("warning status missing");
   bad_data_a: assert property (cmd_valid_in && cmd_write_in && cmd_word_in && is_lim // [R14]
      && sel_ok && w_bad |=> s_q.cml_data && rsp_error_out && !alert_n_out)
      else $error("invalid data not flagged");
   off_clear_a: assert property (!enable_in |=> s_q.tries == 3'h0 && !power_en_out) // [R19]
      else $error("retry count kept after off");
endmodule : ocfm_top

/* File: test/ocfm_host_model.sv */
// Host model: issues one command per pulse and collects the reply
`timescale 1ns/100ps
module ocfm_host_model (
   input wire logic clk_in,
   input wire logic rsp_valid_in,
   input wire logic rsp_error_in,
   input wire logic [15:0] rsp_data_in,
   output logic cmd_valid_out,
   output logic cmd_write_out,
   output logic cmd_word_out,
   output logic [7:0] cmd_code_out,
   output logic [15:0] cmd_wdata_out,
   output logic [7:0] phase_sel_out
);
   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_write_out = 1'b0;
      cmd_word_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_wdata_out = 16'h0000;
      phase_sel_out = 8'h00;
   end
   // Word size is taken from the caller, so a test can send the wrong size on purpose
   task xfer(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] data,
      input logic [7:0] ph, output logic err, output logic [15:0] dat);
      @(negedge clk_in);
      cmd_valid_out = 1'b1;
      cmd_write_out = wr;
      cmd_word_out = wd;
      cmd_code_out = code;
      cmd_wdata_out = data;
      phase_sel_out = ph;
      @(negedge clk_in);
      cmd_valid_out = 1'b0;
      // Reply lands one or two edges on, depending on register placement
      repeat (2) if (rsp_valid_in !== 1'b1) @(negedge clk_in);
      err = rsp_error_in;
      dat = rsp_data_in;
      // Write data is released to a changing pattern so stale values are not trusted
      cmd_wdata_out = ~data;
   endtask : xfer
endmodule : ocfm_host_model

/* File: test/ocfm_top_tb_top.sv */
// Testbench top: limit commands, phase rules, fault policy and warnings
`timescale 1ns/100ps
module ocfm_top_tb_top;
   logic clk_in, pwm_clk_in, reset_in, en, ok, cv, cw, cwd, rv, re, pe, an, er, nr;
   logic [1:0] ft, wt, wp;
   logic [7:0] cc, ph, sb, si, sc;
   logic [15:0] wd, rd, sw, dt;
   logic [9:0] fs, ws;
   int n_errors = 0;
   int comparisons = 0;
   ocfm_top #(.NPH(2), .HICCUP_BASE_CYC(10)) u_ocfm_top (.clk_in(clk_in), .reset_in(reset_in),
      .pwm_clk_in(pwm_clk_in), .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_word_in(cwd),
      .cmd_code_in(cc), .cmd_wdata_in(wd), .phase_sel_in(ph), .nvm_reload_in(nr),
      .clear_faults_in(1'b0), .enable_in(en), .startup_ok_in(ok), .fault_trip_in(ft),
      .warn_trip_in(wt), .rsp_valid_out(rv), .rsp_error_out(re), .rsp_data_out(rd),
      .fault_step_out(fs), .warn_step_out(ws), .warn_phase_out(wp), .status_byte_out(sb),
      .status_word_out(sw), .status_iout_out(si), .status_cml_out(sc), .alert_n_out(an),
      .power_en_out(pe));
   ocfm_host_model u_ocfm_host_model (.clk_in(clk_in), .rsp_valid_in(rv), .rsp_error_in(re),
      .rsp_data_in(rd), .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_word_out(cwd),
      .cmd_code_out(cc), .cmd_wdata_out(wd), .phase_sel_out(ph));
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Switching clock is offset so its edges never line up with the control clock
   initial
   begin
      pwm_clk_in = 1'b0;
      #1.3;
      forever #7.5 pwm_clk_in = ~pwm_clk_in;
   end
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task c(input logic w, input logic d, input logic [7:0] k, input logic [15:0] v,
      input logic [7:0] p);
      u_ocfm_host_model.xfer(w, d, k, v, p, er, dt);
   endtask : c
   task t_reset;
      chk("fstep", 16'h03FF, 16'(fs));
      chk("wstep", 16'h0339, 16'(ws));
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'h00);
      chk("flim", 16'hF0F8, dt);
   endtask : t_reset
   task t_phase;
      c(1'b1, 1'b1, 8'h46, 16'hF190, 8'hFF);
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'h00);
      chk("ph0", 16'hF0C8, dt);
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'hFF);
      chk("all", 16'hF190, dt);
      c(1'b1, 1'b1, 8'h46, 16'hF01C, 8'h01);
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'h01);
      chk("ph1", 16'hF01C, dt);
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'h00);
      chk("ph0b", 16'hF0C8, dt);
      chk("steps", 16'h0099, 16'(fs));
      c(1'b1, 1'b1, 8'h46, 16'hE075, 8'h01);
      nr = 1'b1;
      @(negedge clk_in);
      nr = 1'b0;
      c(1'b0, 1'b1, 8'h46, 16'h0000, 8'h01);
      chk("reload", 16'hF01D, dt);
   endtask : t_phase
   task t_refuse;
      c(1'b1, 1'b1, 8'h46, 16'hF0FC, 8'h00);
      chk("err", 16'h0001, 16'(er));
      chk("cml", 16'h0040, 16'(sc & 8'h40));
      chk("alert", 16'h0000, 16'(an));
      c(1'b1, 1'b0, 8'h46, 16'h0020, 8'h00);
      chk("size", 16'h0001, 16'(er));
   endtask : t_refuse
   task t_fault;
      c(1'b1, 1'b0, 8'h47, 16'h00C0, 8'h00);
      en = 1'b1;
      ok = 1'b1;
      repeat (10) @(negedge clk_in);
      chk("pwr_on", 16'h0001, 16'(pe));
      ft = 2'b01;
      repeat (20) @(negedge clk_in);
      chk("pwr_off", 16'h0000, 16'(pe));
      chk("sts", 16'h4090, {sw[15:8], 8'h00} | 16'(sb & 8'h10) | 16'(si & 8'h80));
      ft = 2'b00;
      repeat (60) @(negedge clk_in);
      chk("latch", 16'h0000, 16'(pe));
      en = 1'b0;
      c(1'b1, 1'b0, 8'h47, 16'h0089, 8'h00);
      en = 1'b1;
      repeat (10) @(negedge clk_in);
      chk("pwr_on2", 16'h0001, 16'(pe));
      ft = 2'b01;
      repeat (20) @(negedge clk_in);
      chk("dly_off", 16'h0000, 16'(pe));
      repeat (20) @(negedge clk_in);
      chk("retry_on", 16'h0001, 16'(pe));
      ft = 2'b00;
   endtask : t_fault
   task t_warn;
      wt = 2'b10;
      repeat (6) @(negedge clk_in);
      chk("wph", 16'h0002, 16'(wp));
      chk("wsts", 16'h0021, 16'(si & 8'h20) | 16'(sb & 8'h01));
   endtask : t_warn
   task finish_test;
      if (n_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   initial
   begin
      #20000;
      n_errors++;
      finish_test;
   end
   initial
   begin
      {reset_in, en, ok, ft, wt} = 7'h40;
      nr = 1'b0;
      repeat (12) @(negedge clk_in);
      reset_in = 1'b0;
      repeat (2) @(negedge clk_in);
      t_reset;
      t_phase;
      t_refuse;
      t_fault;
      t_warn;
      finish_test;
   end
endmodule : ocfm_top_tb_top
